// file: src/dbs_pkg.sv
package dbs_pkg;

  // port configuration: 8, 9, 18 or 36 data pins
  localparam int PORT_W = 36;
  // 8-pin parts gate nibbles, the others 9-bit lanes
  localparam int LANE_W = (PORT_W == 8) ? 4 : 9;
  localparam int SEL_N  = PORT_W / LANE_W;
  // address depth kept small so the array stays simulable
  localparam int ADDR_W = 10;
  localparam int BURST_LEN = 2;

  // timing of the host-made input clock pair
  localparam int MCLK_PERIOD_PS = 4000;
  localparam int K_PERIOD_NS    = 80;
  localparam int K_HALF_CYC     = (K_PERIOD_NS * 1000) / (2 * MCLK_PERIOD_PS);
  localparam int K_PH_W         = 5;
  // host phases: drive mid-way through each half so edges see stable pins
  localparam logic [K_PH_W-1:0] PH_LAST = K_PH_W'(2 * K_HALF_CYC - 1);
  localparam logic [K_PH_W-1:0] PH_KFALL = K_PH_W'(K_HALF_CYC - 1);
  localparam logic [K_PH_W-1:0] PH_DAT  = K_PH_W'(K_HALF_CYC / 2);
  localparam logic [K_PH_W-1:0] PH_CMD  = K_PH_W'(K_HALF_CYC + K_HALF_CYC / 2);

  // latencies counted in input clock half cycles after the command edge
  localparam logic [2:0] RD_LAT_PLL  = 3'h5;
  localparam logic [2:0] RD_LAT_NOPLL = 3'h2;
  localparam int WR_LAT = 1;
  localparam int PIPE_N = 6;

  typedef enum logic
  {
    ACC_WRITE = 1'b0,
    ACC_READ  = 1'b1
  } dbs_acc_t;

  typedef struct packed
  {
    logic              vld;
    dbs_acc_t          acc;
    logic [ADDR_W-1:0] addr;
  } dbs_cmd_t;

  localparam dbs_cmd_t CMD_RST = '0;
  localparam logic [SEL_N-1:0] SEL_NONE = '1;

endpackage

// file: src/dbs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dbs_link_if
  import dbs_pkg::*;
;
  logic              k;
  logic              k_n;
  logic              load_cycle_n;
  logic              rw;
  logic [ADDR_W-1:0] addr;
  logic [SEL_N-1:0]  lane_write_sel_n;
  logic              pll_disable_n;
  logic [PORT_W-1:0] dq_h;
  logic              dq_h_oe;
  logic [PORT_W-1:0] dq_d;
  logic              dq_d_oe;
  logic              echo_clk;
  logic              echo_clk_n;
  logic              read_valid_flag;
  logic [PORT_W-1:0] dq;

  // shared data pins resolved from the two enables
  // released pins read as zero: no bus keeper is modelled, so check the enables
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : '0);

  modport dev (
    input  k, k_n, load_cycle_n, rw, addr, lane_write_sel_n, pll_disable_n, dq,
    output dq_d, dq_d_oe, echo_clk, echo_clk_n, read_valid_flag
  );

  modport ctl (
    input  echo_clk, echo_clk_n, read_valid_flag, dq,
    output k, k_n, load_cycle_n, rw, addr, lane_write_sel_n, pll_disable_n, dq_h, dq_h_oe
  );
endinterface
`default_nettype wire

// file: src/dbs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // all bits share one delay so buses stay aligned with their clock pins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // dbs_sync
`default_nettype wire

// file: src/dbs_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - write words sampled on both clock rises
// - read words driven on both clock rises
// - data pins released when no read
// - port width is 8, 9, 18 or 36
// - load low on clock rise starts cycle
// - every access moves two words
// - direction high reads, low writes
// - one address bus sampled on clock rise
// - two nibble selects gate 8-bit data
// - deselected nibble leaves memory unchanged
// - one lane select per 9-bit lane, four on 36 pins
// - deselected lane leaves memory unchanged
// - valid flag aligned with echo clocks
// - free-running echo pair follows input clock
// - pll off selects one-cycle latency
module dbs_dev_end
  import dbs_pkg::*;
(
  // system
  input  wire logic MCLK,
  input  wire logic RST_N,
  // memory link
  dbs_link_if.dev   LINK,
  // status
  output logic      PLL_ON,
  output logic      WRITE_DONE,
  output logic      READ_DONE
);
  localparam int IN_W = 5 + ADDR_W + SEL_N + PORT_W;

  logic [IN_W-1:0]   pins_raw;
  logic [IN_W-1:0]   pins_s;
  logic              s_k;
  logic              s_kn;
  logic              s_load_n;
  logic              s_rw;
  logic              s_pll_n;
  logic [ADDR_W-1:0] s_addr;
  logic [SEL_N-1:0]  s_sel_n;
  logic [PORT_W-1:0] s_dq;

  logic              k_q;
  logic              kn_q;
  logic              k_rise;
  logic              kn_rise;
  logic              edge_p;

  dbs_cmd_t          pipe_q [PIPE_N];
  dbs_cmd_t          new_cmd;

  logic [2:0]        rd_lat;
  dbs_cmd_t          rd_c0;
  dbs_cmd_t          rd_c1;
  logic              rd_hit0;
  logic              rd_hit1;
  dbs_cmd_t          wr_c0;
  dbs_cmd_t          wr_c1;
  logic              wr_hit0;
  logic              wr_hit1;
  logic [ADDR_W:0]   wr_idx;
  logic [ADDR_W:0]   rd_idx;

  logic [PORT_W-1:0] mem [2**(ADDR_W+1)];
  logic [PORT_W-1:0] dq_q;
  logic              oe_q;
  logic              echo_q;
  logic              echo_n_q;

  // the pins come from the controller's clock domain
  assign pins_raw = {LINK.k, LINK.k_n, LINK.load_cycle_n, LINK.rw, LINK.pll_disable_n,
                     LINK.addr, LINK.lane_write_sel_n, LINK.dq};

  // reset to idle levels so release makes no false edge or load
  dbs_sync #(
    .W       (IN_W),
    .RST_VAL ({IN_W{1'b1}})
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     (pins_raw),
    .q     (pins_s)
  );

  assign {s_k, s_kn, s_load_n, s_rw, s_pll_n, s_addr, s_sel_n, s_dq} = pins_s;

  // rising edges of the input clock pair
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      k_q  <= 1'b1;
      kn_q <= 1'b1;
    end
    else
    begin
      k_q  <= s_k;
      kn_q <= s_kn;
    end
  end

  assign k_rise  = s_k & ~k_q;
  assign kn_rise = s_kn & ~kn_q;
  assign edge_p  = k_rise | kn_rise;

  // load taken on positive rise only
  always_comb
  begin
    new_cmd      = CMD_RST;
    new_cmd.vld  = k_rise & ~s_load_n;
    new_cmd.acc  = dbs_acc_t'(s_rw);
    new_cmd.addr = s_addr;
  end

  // stage i holds the command issued i+1 half cycles ago
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < PIPE_N; i++)
      begin
        pipe_q[i] <= CMD_RST;
      end
    end
    else if (edge_p)
    begin
      pipe_q[0] <= new_cmd;
      for (int i = 1; i < PIPE_N; i++)
      begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign rd_lat = s_pll_n ? RD_LAT_PLL : RD_LAT_NOPLL;

  assign rd_c0   = pipe_q[rd_lat - 3'h1];
  assign rd_c1   = pipe_q[rd_lat];
  assign rd_hit0 = rd_c0.vld && (rd_c0.acc == ACC_READ);
  assign rd_hit1 = rd_c1.vld && (rd_c1.acc == ACC_READ);
  assign rd_idx  = rd_hit0 ? {rd_c0.addr, 1'b0} : {rd_c1.addr, 1'b1};

  // write words expected one and two half cycles after load
  assign wr_c0   = pipe_q[WR_LAT - 1];
  assign wr_c1   = pipe_q[WR_LAT];
  assign wr_hit0 = wr_c0.vld && (wr_c0.acc == ACC_WRITE);
  assign wr_hit1 = wr_c1.vld && (wr_c1.acc == ACC_WRITE);
  assign wr_idx  = wr_hit0 ? {wr_c0.addr, 1'b0} : {wr_c1.addr, 1'b1};

  // data taken on each input clock rise
  // each select gates its own lane
  always_ff @(posedge MCLK)
  begin
    if (edge_p && (wr_hit0 || wr_hit1))
    begin
      for (int l = 0; l < SEL_N; l++)
      begin
        if (!s_sel_n[l])
        begin
          mem[wr_idx][l*LANE_W +: LANE_W] <= s_dq[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // one word per input clock rise
  // pins released on any edge without a read word
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      dq_q <= '0;
      oe_q <= 1'b0;
    end
    else if (edge_p)
    begin
      oe_q <= rd_hit0 | rd_hit1;
      if (rd_hit0 || rd_hit1)
      begin
        dq_q <= mem[rd_idx];
      end
    end
  end

  // echo pair copies the sampled input clocks
  // echo, data and valid all change on one edge
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      echo_q   <= 1'b0;
      echo_n_q <= 1'b0;
    end
    else
    begin
      echo_q   <= s_k;
      echo_n_q <= s_kn;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      WRITE_DONE <= 1'b0;
      READ_DONE  <= 1'b0;
      PLL_ON     <= 1'b0;
    end
    else
    begin
      WRITE_DONE <= edge_p & wr_hit1 & ~wr_hit0;
      READ_DONE  <= edge_p & rd_hit1 & ~rd_hit0;
      PLL_ON     <= s_pll_n;
    end
  end

  assign LINK.dq_d            = dq_q;
  assign LINK.dq_d_oe         = oe_q;
  assign LINK.read_valid_flag = oe_q;
  assign LINK.echo_clk        = echo_q;
  assign LINK.echo_clk_n      = echo_n_q;

endmodule // dbs_dev_end
`default_nettype wire

// file: src/dbs_ctl_end.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_ctl_end
  import dbs_pkg::*;
(
  // system
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // memory link
  dbs_link_if.ctl                LINK,
  // command
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire logic              CMD_READ,
  input  wire logic [ADDR_W-1:0] CMD_ADDR,
  input  wire logic [PORT_W-1:0] CMD_WDATA0,
  input  wire logic [PORT_W-1:0] CMD_WDATA1,
  input  wire logic [SEL_N-1:0]  CMD_WSEL0_N,
  input  wire logic [SEL_N-1:0]  CMD_WSEL1_N,
  input  wire logic              PLL_ENABLE,
  // read answer
  output logic                   RSP_VALID,
  output logic      [PORT_W-1:0] RSP_DATA0,
  output logic      [PORT_W-1:0] RSP_DATA1
);
  localparam int IN_W = 3 + PORT_W;

  logic [K_PH_W-1:0] ph_q;
  logic              k_q;
  logic              kn_q;
  logic              take;
  logic              load_n_q;
  logic              rw_q;
  logic [ADDR_W-1:0] addr_q;
  logic [PORT_W-1:0] wbuf1_q;
  logic [SEL_N-1:0]  wsel1_q;
  logic [PORT_W-1:0] wbuf0_q;
  logic [SEL_N-1:0]  wsel0_q;
  logic              wpend0_q;
  logic              wpend1_q;
  logic [PORT_W-1:0] dq_q;
  logic [SEL_N-1:0]  sel_q;
  logic              oe_q;

  logic [IN_W-1:0]   rd_s;
  logic              s_echo;
  logic              s_echo_n;
  logic              s_vld;
  logic [PORT_W-1:0] s_dq;
  logic              echo_q;
  logic              echo_n_q;
  logic              word_q;

  // input clock pair from a divider of the system clock
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ph_q <= '0;
      k_q  <= 1'b0;
      kn_q <= 1'b1;
    end
    else
    begin
      ph_q <= (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
      if (ph_q == PH_LAST)
      begin
        k_q  <= 1'b1;
        kn_q <= 1'b0;
      end
      else if (ph_q == PH_KFALL)
      begin
        k_q  <= 1'b0;
        kn_q <= 1'b1;
      end
    end
  end

  // one command slot per input clock period, mid-way through low half
  assign CMD_READY = (ph_q == PH_CMD);
  assign take      = CMD_VALID & CMD_READY;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      load_n_q <= 1'b1;
      rw_q     <= 1'b1;
      addr_q   <= '0;
    end
    else if (ph_q == PH_CMD)
    begin
      load_n_q <= ~take;
      if (take)
      begin
        rw_q   <= CMD_READ;
        addr_q <= CMD_ADDR;
      end
    end
  end

  // write words: first held over the negative rise, second over the next positive
  // words at fixed latency
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      wpend0_q <= 1'b0;
      wpend1_q <= 1'b0;
      wbuf0_q  <= '0;
      wbuf1_q  <= '0;
      wsel0_q  <= SEL_NONE;
      wsel1_q  <= SEL_NONE;
      dq_q     <= '0;
      sel_q    <= SEL_NONE;
      oe_q     <= 1'b0;
    end
    else if (ph_q == PH_CMD)
    begin
      if (wpend1_q)
      begin
        dq_q  <= wbuf1_q;
        sel_q <= wsel1_q;
      end
      wpend1_q <= 1'b0;
      wpend0_q <= take & ~CMD_READ;
      if (take && !CMD_READ)
      begin
        wbuf0_q <= CMD_WDATA0;
        wsel0_q <= CMD_WSEL0_N;
        wbuf1_q <= CMD_WDATA1;
        wsel1_q <= CMD_WSEL1_N;
      end
    end
    else if (ph_q == PH_DAT)
    begin
      oe_q     <= wpend0_q;
      wpend1_q <= wpend0_q;
      wpend0_q <= 1'b0;
      dq_q     <= wpend0_q ? wbuf0_q : '0;
      sel_q    <= wpend0_q ? wsel0_q : SEL_NONE;
    end
  end

  // read capture on the echo clocks, both synchronised alike
  dbs_sync #(
    .W       (IN_W),
    .RST_VAL ({IN_W{1'b0}})
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     ({LINK.echo_clk, LINK.echo_clk_n, LINK.read_valid_flag, LINK.dq}),
    .q     (rd_s)
  );

  assign {s_echo, s_echo_n, s_vld, s_dq} = rd_s;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      echo_q    <= 1'b0;
      echo_n_q  <= 1'b0;
      word_q    <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA0 <= '0;
      RSP_DATA1 <= '0;
    end
    else
    begin
      echo_q    <= s_echo;
      echo_n_q  <= s_echo_n;
      RSP_VALID <= 1'b0;
      if (((s_echo && !echo_q) || (s_echo_n && !echo_n_q)) && s_vld)
      begin
        word_q <= ~word_q;
        if (!word_q)
        begin
          RSP_DATA0 <= s_dq;
        end
        else
        begin
          RSP_DATA1 <= s_dq;
          RSP_VALID <= 1'b1;
        end
      end
    end
  end

  assign LINK.k                = k_q;
  assign LINK.k_n              = kn_q;
  assign LINK.load_cycle_n     = load_n_q;
  assign LINK.rw               = rw_q;
  assign LINK.addr             = addr_q;
  assign LINK.lane_write_sel_n = sel_q;
  assign LINK.pll_disable_n    = PLL_ENABLE;
  assign LINK.dq_h             = dq_q;
  assign LINK.dq_h_oe          = oe_q;

endmodule // dbs_ctl_end
`default_nettype wire

// file: dv/dbs_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_link_chk (
  // system
  input wire logic MCLK,
  input wire logic RST_N,
  // link
  input wire logic k,
  input wire logic load_cycle_n,
  input wire logic rw,
  input wire logic pll_disable_n,
  input wire logic dq_h_oe,
  input wire logic dq_d_oe,
  input wire logic echo_clk,
  input wire logic echo_clk_n,
  input wire logic read_valid_flag
);
  logic [5:0] up_q;
  logic [7:0] run_q;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  // echo pair is only trusted once the sync pipes have filled
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      up_q <= '0;
    else if (up_q != 6'h3F)
      up_q <= up_q + 6'h01;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N || !dq_d_oe)
      run_q <= '0;
    else
      run_q <= run_q + 8'h01;
  end

  property p_vld_oe;
    read_valid_flag == dq_d_oe;
  endproperty
  a_vld_oe: assert property (p_vld_oe) else $error("valid flag differs from drive");
  property p_vld_edge;
    $changed(read_valid_flag) |-> $rose(echo_clk) || $rose(echo_clk_n);
  endproperty
  a_vld_edge: assert property (p_vld_edge) else $error("valid flag off echo edge");
  property p_echo;
    up_q == 6'h3F && $rose(echo_clk) |-> ##10 $rose(echo_clk_n) ##10 $rose(echo_clk);
  endproperty
  a_echo: assert property (p_echo) else $error("echo pair not following clock");
  property p_burst;
    $fell(dq_d_oe) |-> run_q != 8'h00 && run_q % 8'h14 == 8'h00;
  endproperty
  a_burst: assert property (p_burst) else $error("read drive not two words");
  property p_rd_lat;
    $rose(k) && !load_cycle_n && rw && pll_disable_n |-> ##[48:60] $rose(dq_d_oe);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
  property p_rd_off;
    $rose(k) && !load_cycle_n && rw && !pll_disable_n |-> ##[18:30] $rose(dq_d_oe);
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("short latency wrong");
  property p_ld_setup;
    $changed(load_cycle_n) || $changed(rw) |-> !k [*4];
  endproperty
  a_ld_setup: assert property (p_ld_setup) else $error("command moved near clock rise");
  property p_no_clash;
    !(dq_d_oe && dq_h_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  property p_wr_win;
    $rose(k) && !load_cycle_n && !rw |-> ##6 dq_h_oe ##19 dq_h_oe;
  endproperty
  a_wr_win: assert property (p_wr_win) else $error("write words not presented");

  c_rd: cover property ($rose(dq_d_oe) && pll_disable_n);
  c_off: cover property ($rose(dq_d_oe) && !pll_disable_n);
  c_wr: cover property ($rose(dq_h_oe));
endmodule // dbs_link_chk
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dbs_pkg::*;
;
  typedef logic [PORT_W-1:0] dbs_word_t;
  logic              MCLK;
  logic              RST_N;
  logic              cmd_valid, cmd_ready, cmd_read, pll_en, pll_on, rsp_valid;
  logic [ADDR_W-1:0] cmd_addr;
  logic [SEL_N-1:0]  ws0, ws1;
  dbs_word_t         wd0, wd1, rd0, rd1;
  dbs_word_t         m0 [2**ADDR_W];
  dbs_word_t         m1 [2**ADDR_W];
  logic [ADDR_W-1:0] tbl [3] = '{10'h000, 10'h3FF, 10'h155};
  int                n_fail = 0, total_checks = 0, n_rsp = 0;
  logic              wr_done, rd_done;
  int                n_wr = 0, n_rd = 0, n_wdone = 0, n_rdone = 0;

  dbs_link_if dbs_link_if_i ();
  dbs_dev_end dbs_dev_end_i (.MCLK(MCLK), .RST_N(RST_N), .LINK(dbs_link_if_i), .PLL_ON(pll_on),
    .WRITE_DONE(wr_done), .READ_DONE(rd_done));
  dbs_ctl_end dbs_ctl_end_i (.MCLK(MCLK), .RST_N(RST_N), .LINK(dbs_link_if_i), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_READ(cmd_read), .CMD_ADDR(cmd_addr), .CMD_WDATA0(wd0), .CMD_WDATA1(wd1),
    .CMD_WSEL0_N(ws0), .CMD_WSEL1_N(ws1), .PLL_ENABLE(pll_en), .RSP_VALID(rsp_valid),
    .RSP_DATA0(rd0), .RSP_DATA1(rd1));
  dbs_link_chk dbs_link_chk_i (.MCLK(MCLK), .RST_N(RST_N), .k(dbs_link_if_i.k),
    .load_cycle_n(dbs_link_if_i.load_cycle_n), .rw(dbs_link_if_i.rw),
    .pll_disable_n(dbs_link_if_i.pll_disable_n), .dq_h_oe(dbs_link_if_i.dq_h_oe),
    .dq_d_oe(dbs_link_if_i.dq_d_oe), .echo_clk(dbs_link_if_i.echo_clk),
    .echo_clk_n(dbs_link_if_i.echo_clk_n), .read_valid_flag(dbs_link_if_i.read_valid_flag));

  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // response pulse lasts one cycle, so count it here rather than poll for it
  always @(posedge MCLK)
  begin
    if (rsp_valid === 1'b1)
      n_rsp <= n_rsp + 1;
    if (wr_done === 1'b1)
      n_wdone <= n_wdone + 1;
    if (rd_done === 1'b1)
      n_rdone <= n_rdone + 1;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_d(input dbs_word_t got, input dbs_word_t exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("Error at %0t: wait ran out, got %h exp %h", $time, 1'b0, 1'b1);
    results();
  endtask

  function automatic dbs_word_t pat(input int s);
    return dbs_word_t'(s) * 36'h1_2345_6789 + 36'h0_F0F0_F0F0;
  endfunction

  // hold the command until ready is seen, then update the model
  task automatic issue(input logic rd, input logic [ADDR_W-1:0] a, input dbs_word_t w0,
                       input dbs_word_t w1, input logic [SEL_N-1:0] s0, input logic [SEL_N-1:0] s1);
    int n;
    n = 0;
    @(posedge MCLK);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_addr  <= a;
    wd0       <= w0;
    wd1       <= w1;
    ws0       <= s0;
    ws1       <= s1;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 30);
    cmd_valid <= 1'b0;
    if (n >= 30)
      hang();
    if (rd)
      n_rd++;
    else
      n_wr++;
    for (int i = 0; i < SEL_N; i++)
    begin
      if (!rd && !s0[i])
        m0[a][i*LANE_W +: LANE_W] = w0[i*LANE_W +: LANE_W];
      if (!rd && !s1[i])
        m1[a][i*LANE_W +: LANE_W] = w1[i*LANE_W +: LANE_W];
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a);
    int n, r;
    n = 0;
    r = n_rsp;
    issue(1'b1, a, '0, '0, SEL_NONE, SEL_NONE);
    while (dbs_link_if_i.read_valid_flag !== 1'b1 && n < 100)
    begin
      @(posedge MCLK);
      n++;
    end
    repeat (2) @(posedge MCLK);
    chk_d(dbs_word_t'(dbs_link_if_i.read_valid_flag), dbs_word_t'(1'b1));
    chk_d(dbs_link_if_i.dq, m0[a]);
    repeat (10) @(posedge MCLK);
    chk_d(dbs_link_if_i.dq, m1[a]);
    while (n_rsp == r && n < 100)
    begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 100)
      hang();
    chk_d(rd0, m0[a]);
    chk_d(rd1, m1[a]);
    repeat (12) @(posedge MCLK);
    chk_d(dbs_word_t'(dbs_link_if_i.dq_d_oe), '0);
  endtask

  initial
  begin
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_addr  = '0;
    wd0       = '0;
    wd1       = '0;
    ws0       = SEL_NONE;
    ws1       = SEL_NONE;
    pll_en    = 1'b1;
    RST_N     = 1'b0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (8) @(posedge MCLK);
    chk_d(dbs_word_t'(pll_on), dbs_word_t'(1'b1));
    // back-to-back writes, edge addresses included
    for (int j = 0; j < 3; j++)
      issue(1'b0, tbl[j], pat(2 * j), pat(2 * j + 1), '0, '0);
    repeat (40) @(posedge MCLK);
    for (int j = 0; j < 3; j++)
      rd_chk(tbl[j]);
    $display("test full_burst done");
    // last pass deselects every lane of word 0
    for (int i = 0; i <= SEL_N; i++)
    begin
      issue(1'b0, tbl[2], pat(10 + i), pat(20 + i), ~(SEL_N'(1) << i), SEL_N'(1) << i);
      repeat (40) @(posedge MCLK);
      rd_chk(tbl[2]);
    end
    $display("test lane_select done");
    pll_en <= 1'b0;
    repeat (20) @(posedge MCLK);
    chk_d(dbs_word_t'(pll_on), dbs_word_t'(1'b0));
    issue(1'b0, tbl[1], pat(30), pat(31), '0, '0);
    repeat (40) @(posedge MCLK);
    rd_chk(tbl[1]);
    rd_chk(tbl[0]);
    $display("test pll_off done");
    chk_d(dbs_word_t'(n_wdone), dbs_word_t'(n_wr));
    chk_d(dbs_word_t'(n_rdone), dbs_word_t'(n_rd));
    results();
  end
endmodule // testbench
`default_nettype wire
